// ==== shared/pin_port_pkg.sv ====
// What this block does
// - Up to seven host-written pin latches, pin levels readable by the host.
// - Reset and default: open-drain, pull-up on, every latch at one.
// - After reset each pin acts as an input the host can sample.
// - Separate pin states for normal running, suspend, and just after reset.
// - Push-pull pin drives both levels straight from its latch.
// - Open-drain pin drives low on zero, releases to pull-up on one.
// - 28-pin map: pins 0..3 tx toggle, rx toggle, RS-485 direction, wakeup.
// - 20-pin map: pins 0..3 clock, RS-485 direction, tx, rx; 4..6 absent.
// - Dynamic suspend off: latches stay unchanged through suspend.
// - Dynamic suspend on: entering suspend from configured loads suspend values.
// - Leaving suspend with dynamic suspend on restores the pre-suspend latches.
// - Pin group and serial group have their own dynamic-suspend enable and values.
// - Charging enabled: charger port type sets the three charge outputs.
// - Base output allows 100 mA, middle 500 mA, high 1.5 A.
// - In suspend charge outputs drop only for a standard data port.
// - Bus suspend signalling puts the device into suspend.
// - Resume, bus reset, device reset or enabled wakeup pin leave suspend.
package pin_port_pkg;
  localparam int NUM_PINS = 7;
  localparam int SER_PINS = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_LATCH = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_LEVEL = 8'h08;
  localparam logic [7:0] OFF_SUSP_VAL = 8'h0C;
  localparam logic [7:0] OFF_SER_LATCH = 8'h10;
  localparam logic [7:0] OFF_SER_SUSP = 8'h14;
  localparam logic [7:0] OFF_CTRL = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  // Values after reset
  localparam logic [6:0] LATCH_RST = 7'h7F;
  localparam logic [6:0] MODE_RST = 7'h00;
  localparam logic [6:0] SUSP_VAL_RST = 7'h7F;
  localparam logic [7:0] SER_LATCH_RST = 8'hFF;
  localparam logic [7:0] SER_SUSP_RST = 8'hFF;
  localparam logic [11:0] CTRL_RST = 12'h000;
  // Control field positions
  localparam int CTRL_DYN_GPIO = 0;
  localparam int CTRL_DYN_SER = 1;
  localparam int CTRL_VAR20 = 2;
  localparam int CTRL_CHG_EN = 3;
  localparam int CTRL_WAKE_EN = 4;
  localparam int CTRL_ALT_LSB = 8;
  localparam int CTRL_ALT_MSB = 11;
  // Status field positions
  localparam int STAT_SUSP = 0;
  localparam int STAT_PORT_LSB = 1;
  localparam int STAT_CHG_LSB = 3;
  typedef enum logic [0:0] {
    ST_ACTIVE = 1'b0,
    ST_SUSPENDED = 1'b1
  } susp_state_t;
  typedef enum logic [1:0] {
    PORT_NONE = 2'b00,
    PORT_SDP = 2'b01,
    PORT_CDP = 2'b10,
    PORT_DCP = 2'b11
  } port_type_t;
  typedef enum logic [2:0] {
    ALT_NONE = 3'b000,
    ALT_TXT = 3'b001,
    ALT_RXT = 3'b010,
    ALT_RS485 = 3'b011,
    ALT_WAKE = 3'b100,
    ALT_CLK = 3'b101,
    ALT_ABSENT = 3'b110
  } alt_t;
endpackage

// ==== hdl/host_controlled_pin_port.sv ====
module host_controlled_pin_port
  import pin_port_pkg::*;
(
  // Clock, reset, freeze
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // USB device state events
  input wire logic usb_configured,
  input wire logic usb_suspend_det,
  input wire logic usb_resume_det,
  input wire logic usb_bus_reset,
  input wire logic [1:0] charger_type,
  // Alternate function sources
  input wire logic tx_activity_toggle,
  input wire logic rx_activity_toggle,
  input wire logic rs485_dir,
  input wire logic clk_out_sig,
  // Pins
  input wire logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_oe,
  output logic [NUM_PINS-1:0] gpio_pullup_en,
  // Serial group latches and suspend state
  output logic [SER_PINS-1:0] ser_latch,
  output logic suspended,
  // Charge select
  output logic charge_base_enable,
  output logic charge_mid_enable,
  output logic charge_high_enable
);

  // Alternate function per pin and package variant
  function automatic alt_t alt_of(input int pin, input logic var20);
    alt_t a;
    a = ALT_NONE;
    case (pin)
      0: a = var20 ? ALT_CLK : ALT_TXT;
      1: a = var20 ? ALT_RS485 : ALT_RXT;
      2: a = var20 ? ALT_TXT : ALT_RS485;
      3: a = var20 ? ALT_RXT : ALT_WAKE;
      default: a = var20 ? ALT_ABSENT : ALT_NONE;
    endcase
    return a;
  endfunction

  // Register select, used by both read and write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  logic [6:0] latch_reg;
  logic [6:0] mode_reg;
  logic [6:0] susp_val_reg;
  logic [6:0] saved_reg;
  logic [7:0] ser_latch_reg;
  logic [7:0] ser_susp_reg;
  logic [7:0] ser_saved_reg;
  logic [11:0] ctrl_reg;
  logic saved_valid_reg;
  logic ser_saved_valid_reg;
  susp_state_t state_reg;
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] sync3_reg;
  logic [6:0] level_reg;
  logic [6:0] level_next;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rdata_next;
  logic addr_ok;
  logic wr_latch;
  logic wr_ser;
  logic wake_fall;
  logic enter_susp;
  logic exit_susp;
  logic [6:0] pin_out_next;
  logic [6:0] pin_oe_next;
  logic [6:0] pin_pull_next;

  // Bus handshake: no wait states, but a frozen block holds the bus off
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign addr_ok = hsel && hready && htrans[1] && ce;
  assign wr_latch = ce && wr_pend_reg && hit(wr_addr_reg, OFF_LATCH);
  assign wr_ser = ce && wr_pend_reg && hit(wr_addr_reg, OFF_SER_LATCH);

  // Address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (ce) begin
      wr_pend_reg <= addr_ok && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  // Read mux, sampled in the address phase; unmapped offsets read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit(haddr[7:0], OFF_LATCH)) rdata_next[6:0] = latch_reg;
    if (hit(haddr[7:0], OFF_MODE)) rdata_next[6:0] = mode_reg;
    if (hit(haddr[7:0], OFF_LEVEL)) rdata_next[6:0] = level_reg;
    if (hit(haddr[7:0], OFF_SUSP_VAL)) rdata_next[6:0] = susp_val_reg;
    if (hit(haddr[7:0], OFF_SER_LATCH)) rdata_next[7:0] = ser_latch_reg;
    if (hit(haddr[7:0], OFF_SER_SUSP)) rdata_next[7:0] = ser_susp_reg;
    if (hit(haddr[7:0], OFF_CTRL)) rdata_next[11:0] = ctrl_reg;
    if (hit(haddr[7:0], OFF_STATUS)) begin
      rdata_next[STAT_SUSP] = state_reg == ST_SUSPENDED;
      rdata_next[STAT_PORT_LSB+:2] = charger_type;
      rdata_next[STAT_CHG_LSB+:3] = {charge_high_enable, charge_mid_enable, charge_base_enable};
    end
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rdata_next;
    end
  end

  // Configuration registers written by the host
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= MODE_RST;
      susp_val_reg <= SUSP_VAL_RST;
      ser_susp_reg <= SER_SUSP_RST;
      ctrl_reg <= CTRL_RST;
    end else if (ce && wr_pend_reg) begin
      if (hit(wr_addr_reg, OFF_MODE)) mode_reg <= hwdata[6:0];
      if (hit(wr_addr_reg, OFF_SUSP_VAL)) susp_val_reg <= hwdata[6:0];
      if (hit(wr_addr_reg, OFF_SER_SUSP)) ser_susp_reg <= hwdata[7:0];
      if (hit(wr_addr_reg, OFF_CTRL)) ctrl_reg <= hwdata[11:0];
    end
  end

  // Pin input synchroniser; a change counts once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= LATCH_RST;
      sync2_reg <= LATCH_RST;
      sync3_reg <= LATCH_RST;
      level_reg <= LATCH_RST;
    end else if (ce) begin
      sync1_reg <= gpio_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= level_next;
    end
  end

  // Accept only agreed values, so a single-cycle glitch never reaches the host
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (sync2_reg[i] == sync3_reg[i]) level_next[i] = sync3_reg[i];
    end
  end

  // Wakeup pin: falling edge, only where pin 3 carries the wakeup function
  assign wake_fall = ctrl_reg[CTRL_WAKE_EN] && !ctrl_reg[CTRL_VAR20]
                     && ctrl_reg[CTRL_ALT_LSB + 3] && level_reg[3] && !level_next[3];
  assign enter_susp = state_reg == ST_ACTIVE && usb_suspend_det;
  assign exit_susp = state_reg == ST_SUSPENDED
                     && (usb_resume_det || usb_bus_reset || wake_fall);

  // Suspend state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_ACTIVE;
    end else if (ce) begin
      case (state_reg)
        ST_ACTIVE: if (usb_suspend_det) state_reg <= ST_SUSPENDED;
        ST_SUSPENDED: if (exit_susp) state_reg <= ST_ACTIVE;
        default: state_reg <= ST_ACTIVE;
      endcase
    end
  end

  assign suspended = state_reg == ST_SUSPENDED;

  // Pin latches; suspend load and restore take priority over a host write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_reg <= LATCH_RST;
      saved_reg <= LATCH_RST;
      saved_valid_reg <= 1'b0;
    end else if (ce) begin
      if (enter_susp && usb_configured && ctrl_reg[CTRL_DYN_GPIO]) begin
        saved_reg <= latch_reg;
        latch_reg <= susp_val_reg;
        saved_valid_reg <= 1'b1;
      end else if (exit_susp && saved_valid_reg) begin
        latch_reg <= saved_reg;
        saved_valid_reg <= 1'b0;
      end else if (wr_latch) begin
        latch_reg <= hwdata[6:0];
      end
    end
  end

  // Serial group latches, own enable and own suspend values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ser_latch_reg <= SER_LATCH_RST;
      ser_saved_reg <= SER_LATCH_RST;
      ser_saved_valid_reg <= 1'b0;
    end else if (ce) begin
      if (enter_susp && usb_configured && ctrl_reg[CTRL_DYN_SER]) begin
        ser_saved_reg <= ser_latch_reg;
        ser_latch_reg <= ser_susp_reg;
        ser_saved_valid_reg <= 1'b1;
      end else if (exit_susp && ser_saved_valid_reg) begin
        ser_latch_reg <= ser_saved_reg;
        ser_saved_valid_reg <= 1'b0;
      end else if (wr_ser) begin
        ser_latch_reg <= hwdata[7:0];
      end
    end
  end

  assign ser_latch = ser_latch_reg;

  // Per-pin drive: alternate function first, then push-pull or open-drain
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      logic alt_on;
      alt_t kind;
      assign kind = alt_of(g, ctrl_reg[CTRL_VAR20]);
      if (g <= 3) begin : g_alt
        assign alt_on = ctrl_reg[CTRL_ALT_LSB + g];
      end else begin : g_noalt
        assign alt_on = 1'b0;
      end
      always_comb begin
        pin_out_next[g] = latch_reg[g];
        pin_oe_next[g] = mode_reg[g] || !latch_reg[g];
        pin_pull_next[g] = !mode_reg[g];
        if (kind == ALT_ABSENT) begin
          pin_out_next[g] = 1'b0;
          pin_oe_next[g] = 1'b0;
          pin_pull_next[g] = 1'b0;
        end else if (alt_on && kind == ALT_WAKE) begin
          pin_out_next[g] = 1'b1;
          pin_oe_next[g] = 1'b0;
          pin_pull_next[g] = 1'b1;
        end else if (alt_on && kind != ALT_NONE) begin
          pin_oe_next[g] = 1'b1;
          pin_pull_next[g] = 1'b0;
          case (kind)
            ALT_TXT: pin_out_next[g] = tx_activity_toggle;
            ALT_RXT: pin_out_next[g] = rx_activity_toggle;
            ALT_RS485: pin_out_next[g] = rs485_dir;
            ALT_CLK: pin_out_next[g] = clk_out_sig && !suspended;
            default: pin_out_next[g] = latch_reg[g];
          endcase
        end
      end
    end
  endgenerate

  // Pin drive registers; reset leaves every pin released onto its pull-up
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_out <= LATCH_RST;
      gpio_oe <= 7'h00;
      gpio_pullup_en <= 7'h7F;
    end else if (ce) begin
      gpio_out <= pin_out_next;
      gpio_oe <= pin_oe_next;
      gpio_pullup_en <= pin_pull_next;
    end
  end

  // Charge select from detected port; SDP drops all outputs in suspend
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      charge_base_enable <= 1'b0;
      charge_mid_enable <= 1'b0;
      charge_high_enable <= 1'b0;
    end else if (ce) begin
      if (!ctrl_reg[CTRL_CHG_EN] || charger_type == PORT_NONE
          || (suspended && charger_type == PORT_SDP)) begin
        charge_base_enable <= 1'b0;
        charge_mid_enable <= 1'b0;
        charge_high_enable <= 1'b0;
      end else begin
        charge_base_enable <= 1'b1;
        charge_mid_enable <= 1'b1;
        charge_high_enable <= charger_type != PORT_SDP;
      end
    end
  end

  // Checks
  chk_reset_latch: assert property (@(posedge hclk) $rose(hresetn) |->
    latch_reg == LATCH_RST && gpio_oe == 7'h00 && gpio_pullup_en == 7'h7F)
    else $error("latches or pin drive wrong after reset");
  chk_push_pull: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !ctrl_reg[CTRL_VAR20] && mode_reg[6]
    |=> gpio_oe[6] && gpio_out[6] == $past(latch_reg[6]))
    else $error("push-pull pin not driving its latch");
  chk_od_release: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !ctrl_reg[CTRL_VAR20] && !mode_reg[5] && latch_reg[5]
    |=> !gpio_oe[5] && gpio_pullup_en[5])
    else $error("open-drain pin not released at latch one");
  chk_od_low: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !mode_reg[4] && !latch_reg[4] && !ctrl_reg[CTRL_VAR20]
    |=> gpio_oe[4] && !gpio_out[4])
    else $error("open-drain pin not pulled low at latch zero");
  chk_susp_load: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && enter_susp && usb_configured && ctrl_reg[CTRL_DYN_GPIO]
    |=> latch_reg == $past(susp_val_reg) && suspended)
    else $error("suspend values not loaded on entry");
  chk_susp_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    suspended && !ctrl_reg[CTRL_DYN_GPIO] && !saved_valid_reg && !wr_latch
    |=> latch_reg == $past(latch_reg))
    else $error("latch moved in suspend without dynamic suspend");
  chk_restore: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && exit_susp && saved_valid_reg
    |=> latch_reg == $past(saved_reg) && !suspended)
    else $error("latches not restored on leaving suspend");
  chk_bus_reset_exit: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && suspended && usb_bus_reset |=> !suspended)
    else $error("bus reset did not end suspend");
  chk_charge_sdp: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && suspended && charger_type == PORT_SDP
    |=> !charge_base_enable && !charge_mid_enable && !charge_high_enable)
    else $error("charge outputs left on in suspend at SDP");
  chk_charge_dcp: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && ctrl_reg[CTRL_CHG_EN] && charger_type == PORT_DCP
    |=> charge_base_enable && charge_mid_enable && charge_high_enable)
    else $error("charge outputs wrong for a charging port");
  cov_susp_cycle: cover property (@(posedge hclk) disable iff (!hresetn)
    ce && enter_susp && ctrl_reg[CTRL_DYN_GPIO] ##[1:50] ce && exit_susp);
  cov_wake: cover property (@(posedge hclk) disable iff (!hresetn) ce && wake_fall);
  cov_write_latch: cover property (@(posedge hclk) disable iff (!hresetn) wr_latch);

endmodule

// ==== verif/pin_pad_model.sv ====
module pin_pad_model
  import pin_port_pkg::*;
(
  // Clock
  input wire logic hclk,
  // Design pin drive
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  input wire logic [NUM_PINS-1:0] gpio_pullup_en,
  // External circuitry
  input wire logic [NUM_PINS-1:0] ext_en,
  input wire logic [NUM_PINS-1:0] ext_val,
  // Resolved pad level
  output logic [NUM_PINS-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic toggle_reg = 1'b0;

  // A floating pad wanders, so an unpulled released pin never looks stable
  always_ff @(posedge hclk) begin
    toggle_reg <= ~toggle_reg;
  end

  // Design drive wins, then the outside load, then the pull-up
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (gpio_oe[i]) begin
        pin_level[i] = gpio_out[i];
      end else if (ext_en[i]) begin
        pin_level[i] = ext_val[i];
      end else begin
        pin_level[i] = gpio_pullup_en[i] | toggle_reg;
      end
    end
  end
endmodule

// ==== verif/testbench.sv ====
module testbench
  import pin_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, suspended;
  logic [31:0] hrdata;
  logic usb_configured = 1'b1;
  logic [2:0] ev = 3'h0;
  logic [1:0] charger_type = 2'h0;
  logic [3:0] alt_src = 4'h0;
  logic [6:0] ext_en = 7'h0;
  logic [6:0] ext_val = 7'h0;
  logic [6:0] pin_level, gpio_out, gpio_oe, gpio_pullup_en;
  logic [7:0] ser_latch;
  logic [2:0] chg;
  int bad_count = 0;
  int compares = 0;

  host_controlled_pin_port host_controlled_pin_port_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .usb_configured(usb_configured), .usb_suspend_det(ev[0]),
    .usb_resume_det(ev[1]), .usb_bus_reset(ev[2]), .charger_type(charger_type),
    .tx_activity_toggle(alt_src[0]), .rx_activity_toggle(alt_src[1]),
    .rs485_dir(alt_src[2]), .clk_out_sig(alt_src[3]), .gpio_in(pin_level),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pullup_en(gpio_pullup_en),
    .ser_latch(ser_latch), .suspended(suspended), .charge_base_enable(chg[0]),
    .charge_mid_enable(chg[1]), .charge_high_enable(chg[2]));

  pin_pad_model pin_pad_model_i (
    .hclk(hclk), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_pullup_en(gpio_pullup_en), .ext_en(ext_en), .ext_val(ext_val),
    .pin_level(pin_level));

  // 50 ns clock
  initial begin
    forever #25 hclk = ~hclk;
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // Single AHB transfer: address held until hready, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    compares++;
    if (r !== e) begin
      bad_count++;
      $display("mismatch reg %h expected %h seen %h", a, e, r);
    end
  endtask

  task automatic chk_sig(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One-cycle pulse on the USB state event lines
  task automatic pulse(input logic [2:0] m);
    @(posedge hclk);
    ev <= m;
    @(posedge hclk);
    ev <= 3'h0;
    settle(2);
  endtask

  // Hang guard, well past the length of the sequence
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    chk_sig("oe", 8'h00, {1'b0, gpio_oe});
    chk_sig("pullup", 8'h7F, {1'b0, gpio_pullup_en});
    chk_reg(OFF_LATCH, 32'h7F);
    chk_reg(OFF_MODE, 32'h0);
    chk_reg(OFF_LEVEL, 32'h7F);
    chk_reg(OFF_CTRL, 32'h0);
    wr(8'h20, 32'hFFFF);
    chk_reg(8'h20, 32'h0);
    $display("test reset done");
    // Open drain pulls low only where the latch is zero; it is slow, not real time
    wr(OFF_LATCH, 32'h3E);
    settle(6);
    chk_sig("oe", 8'h41, {1'b0, gpio_oe});
    chk_sig("out", 8'h00, {1'b0, gpio_out & gpio_oe});
    chk_reg(OFF_LEVEL, 32'h3E);
    wr(OFF_MODE, 32'h7F);
    settle(2);
    chk_sig("oe", 8'h7F, {1'b0, gpio_oe});
    chk_sig("out", 8'h3E, {1'b0, gpio_out});
    wr(OFF_MODE, 32'h0);
    wr(OFF_LATCH, 32'h7F);
    ext_en <= 7'h20;
    settle(6);
    chk_reg(OFF_LEVEL, 32'h5F);
    wr(OFF_LEVEL, 32'h0);
    chk_reg(OFF_LEVEL, 32'h5F);
    ext_en <= 7'h0;
    ce <= 1'b0;
    settle(1);
    chk_sig("hreadyout", 8'h00, {7'h0, hreadyout});
    chk_sig("hresp", 8'h00, {7'h0, hresp});
    ce <= 1'b1;
    $display("test pins done");
    // Static then dynamic suspend, each group on its own enable
    wr(OFF_LATCH, 32'h55);
    wr(OFF_SUSP_VAL, 32'h0F);
    wr(OFF_SER_LATCH, 32'hA5);
    wr(OFF_SER_SUSP, 32'h11);
    pulse(3'h1);
    chk_sig("suspended", 8'h01, {7'h0, suspended});
    chk_reg(OFF_LATCH, 32'h55);
    pulse(3'h2);
    chk_sig("suspended", 8'h00, {7'h0, suspended});
    wr(OFF_CTRL, 32'h1);
    pulse(3'h1);
    chk_reg(OFF_LATCH, 32'h0F);
    chk_sig("ser", 8'hA5, ser_latch);
    pulse(3'h4);
    chk_sig("suspended", 8'h00, {7'h0, suspended});
    chk_reg(OFF_LATCH, 32'h55);
    wr(OFF_CTRL, 32'h2);
    pulse(3'h1);
    chk_sig("ser", 8'h11, ser_latch);
    chk_reg(OFF_LATCH, 32'h55);
    pulse(3'h2);
    chk_sig("ser", 8'hA5, ser_latch);
    $display("test suspend done");
    // Charge outputs per port type, then in suspend
    wr(OFF_CTRL, 32'h8);
    for (int t = 0; t < 4; t++) begin
      charger_type <= t[1:0];
      settle(2);
      chk_sig("chg", (t == 0) ? 8'h0 : (t == 1) ? 8'h3 : 8'h7, {5'h0, chg});
    end
    pulse(3'h1);
    chk_sig("chg", 8'h07, {5'h0, chg});
    pulse(3'h2);
    charger_type <= 2'h1;
    pulse(3'h1);
    chk_sig("chg", 8'h00, {5'h0, chg});
    pulse(3'h2);
    chk_sig("chg", 8'h03, {5'h0, chg});
    chk_reg(OFF_STATUS, 32'h1A);
    $display("test charge done");
    // Alternate functions in both package maps, wakeup from suspend
    alt_src <= 4'hD;
    wr(OFF_CTRL, 32'hF10);
    settle(2);
    chk_sig("out", 8'h05, {5'h0, gpio_out[2:0]});
    chk_sig("oe", 8'h07, {5'h0, gpio_oe[2:0]});
    pulse(3'h1);
    ext_en <= 7'h08;
    for (int n = 0; n < 20 && suspended !== 1'b0; n++) settle(1);
    chk_sig("suspended", 8'h00, {7'h0, suspended});
    ext_en <= 7'h0;
    wr(OFF_CTRL, 32'hF04);
    settle(2);
    chk_sig("out", 8'h07, {4'h0, gpio_out[3:0]});
    chk_sig("oe", 8'h00, {5'h0, gpio_oe[6:4]});
    chk_sig("pullup", 8'h00, {5'h0, gpio_pullup_en[6:4]});
    $display("test alternate done");
    stop_test();
  end
endmodule
